// ### logic/relay_rec_consts.svh
// constants for the relay record keeping and time sync block
// What this block does
// - sync pulse snaps clock to nearest minute
// - any logic input selectable as sync source
// - special variant: accept after 24 stable samples
// - time tag and keep 250 events
// - full event log overwrites its oldest entry
// - event stamps resolve one millisecond
// - enabled threshold crossing creates fault record
// - keep 25 fault records, overwrite oldest
// - fault stamped at fault, event logged later
// - keep five latest starting records with duration
// - starting record: count, time, stage, duration, trip
// - disturbance length selectable 3, 5, 7, 9 s
// - store holds 5x3, 3x5, 2x7 or 1x9 s
// - full disturbance store overwrites oldest record
// - disturbance samples at 32 per cycle
// - records carry analogue, digital and CT ratio
// - record begins pre-trigger time before trigger
// - records readable by panel and both serials
`ifndef RELAY_REC_CONSTS_SVH
`define RELAY_REC_CONSTS_SVH
`define CLK_NS            100
`define MS_NS             1_000_000
`define LINE_HZ           50
`define SAMPLES_PER_CYCLE 32
`define DEB_SAMPLES       24
`define DEB_PLAIN         1
`define ROUND_SEC         30
`define SEC_PER_MIN       60
`define MIN_PER_HR        60
`define HR_PER_DAY        24
`define MS_PER_SEC        1000
`define EVT_DEPTH         250
`define FLT_DEPTH         25
`define START_DEPTH       5
`define DIST_TOTAL_S      15
`define LEN_A_S           3
`define LEN_B_S           5
`define LEN_C_S           7
`define LEN_D_S           9
`define SLOTS_A           5
`define SLOTS_B           3
`define SLOTS_C           2
`define SLOTS_D           1
`define FAULT_EVT_CODE    8'hF0
`define N_STAGES          6
`endif

// ### logic/relay_rec_pkg.sv
// types shared by the relay record keeping block
package relay_rec_pkg;
	typedef struct packed {
		logic [15:0] day;
		logic [4:0]  hour;
		logic [5:0]  minute;
		logic [5:0]  second;
		logic [9:0]  msec;
	} rtc_t;
	typedef struct packed {
		rtc_t       stamp;
		logic [7:0] code;
	} event_t;
	typedef struct packed {
		rtc_t       stamp;
		logic [5:0] stages;
	} fault_t;
	// stage 0..2 phase stages, 3..5 earth_fault_stage_one..three
	typedef struct packed {
		logic [15:0] fault_count;
		rtc_t        stamp;
		logic [2:0]  stage;
		logic [15:0] dur_ms;
		logic        tripped;
	} start_rec_t;
	typedef struct packed {
		logic [15:0] ia;
		logic [15:0] ib;
		logic [15:0] ic;
		logic [15:0] ie;
		logic [7:0]  digital;
	} sample_t;
	typedef struct packed {
		rtc_t        stamp;
		logic [15:0] start_off;
		logic [15:0] ct_ratio;
		logic [15:0] len_samples;
	} dmeta_t;
	typedef enum logic [3:0] {
		LEN_3S = 4'b0001,
		LEN_5S = 4'b0010,
		LEN_7S = 4'b0100,
		LEN_9S = 4'b1000
	} rec_len_t;
	typedef enum logic [4:0] {
		ST_EVENT = 5'b00001,
		ST_FAULT = 5'b00010,
		ST_START = 5'b00100,
		ST_DIST  = 5'b01000,
		ST_DMETA = 5'b10000
	} store_t;
	typedef enum logic [2:0] {
		PORT_FRONT  = 3'b001,
		PORT_LOCAL  = 3'b010,
		PORT_REMOTE = 3'b100
	} port_t;
	typedef enum logic [1:0] {
		DR_ARM  = 2'b01,
		DR_POST = 2'b10
	} dr_state_t;
	typedef struct packed {
		port_t       port;
		store_t      store;
		logic [15:0] index;
	} rd_req_t;
	typedef struct packed {
		port_t       port;
		logic [95:0] data;
	} rd_rsp_t;
endpackage

// ### logic/relay_record_and_time_sync.sv
// event, fault, starting and disturbance records with minute time sync
`timescale 1ns/1ps
`include "relay_rec_consts.svh"
module relay_record_and_time_sync #(
	parameter int N_IN       = 8,
	parameter int MS_CYCLES  = `MS_NS / `CLK_NS,
	parameter int SPS        = `LINE_HZ * `SAMPLES_PER_CYCLE,
	parameter int DIST_DEPTH = `DIST_TOTAL_S * SPS
) (
	input  wire logic                        ref_clk,
	input  wire logic                        nrst,
	input  wire logic                        sample_tick,
	input  wire logic [N_IN-1:0]             logic_in,
	input  wire logic [$clog2(N_IN)-1:0]     sync_sel,
	input  wire logic                        ea_filter_en,
	input  wire logic [`N_STAGES-1:0]        thresh_cross,
	input  wire logic [`N_STAGES-1:0]        thresh_en,
	input  wire logic                        trip,
	input  wire logic                        event_valid,
	input  wire logic [7:0]                  event_code,
	output logic                             event_ready,
	input  wire relay_rec_pkg::sample_t      sample_in,
	input  wire logic [15:0]                 ct_ratio,
	input  wire relay_rec_pkg::rec_len_t     rec_len,
	input  wire logic [15:0]                 pretrig_samples,
	input  wire logic                        rd_req_valid,
	input  wire relay_rec_pkg::rd_req_t      rd_req,
	output logic                             rd_req_ready,
	output logic                             rd_rsp_valid,
	output relay_rec_pkg::rd_rsp_t           rd_rsp,
	input  wire logic                        rd_rsp_ready,
	output relay_rec_pkg::rtc_t              rtc_now,
	output logic                             dist_busy
);
	import relay_rec_pkg::*;
	localparam int DAW = $clog2(DIST_DEPTH);
	localparam int MSW = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1; // one bit even for 1 cycle/ms

	// ---------------- real-time clock ----------------
	function automatic rtc_t inc_min(rtc_t t);
		rtc_t r;
		r = t;
		r.second = '0;
		r.msec = '0;
		if (r.minute == 6'(`MIN_PER_HR - 1)) begin
			r.minute = '0;
			if (r.hour == 5'(`HR_PER_DAY - 1)) begin
				r.hour = '0;
				r.day = r.day + 16'h0001;
			end else begin
				r.hour = r.hour + 5'h01;
			end
		end else begin
			r.minute = r.minute + 6'h01;
		end
		return r;
	endfunction

	function automatic rtc_t inc_ms(rtc_t t);
		rtc_t r;
		r = t;
		if (t.msec != 10'(`MS_PER_SEC - 1)) begin
			r.msec = t.msec + 10'h001;
		end else if (t.second != 6'(`SEC_PER_MIN - 1)) begin
			r.msec = '0;
			r.second = t.second + 6'h01;
		end else begin
			r = inc_min(t);
		end
		return r;
	endfunction

	function automatic rtc_t snap(rtc_t t);
		rtc_t r;
		r = t;
		r.second = '0;
		r.msec = '0;
		if (t.second >= 6'(`ROUND_SEC)) begin
			r = inc_min(t);
		end
		return r;
	endfunction

	logic [MSW-1:0]               ms_div_q;
	rtc_t                         rtc_q;
	rtc_t                         rtc_d;
	logic                         sync_pulse;
	wire ms_tick = (ms_div_q == MSW'(MS_CYCLES - 1));
	// millisecond granularity of every stamp
	assign rtc_d = sync_pulse ? snap(rtc_q) : (ms_tick ? inc_ms(rtc_q) : rtc_q);
	assign rtc_now = rtc_q;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			ms_div_q <= '0;
			rtc_q <= '0;
		end else begin
			ms_div_q <= ms_tick ? '0 : ms_div_q + MSW'(1);
			rtc_q <= rtc_d;
		end
	end

	// ---------------- sync input debounce ----------------
	logic       sync_stable_q;
	logic       sync_prev_q;
	logic [4:0] deb_cnt_q;
	wire        sync_raw = logic_in[sync_sel];
	wire  [4:0] deb_need = ea_filter_en ? 5'(`DEB_SAMPLES) : 5'(`DEB_PLAIN);
	wire        deb_diff = sync_raw != sync_stable_q;
	wire        deb_done = deb_diff && (deb_cnt_q + 5'h01 >= deb_need);
	// one snap per rising edge; a held input does nothing more
	assign sync_pulse = sync_stable_q & ~sync_prev_q;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			sync_stable_q <= 1'b0;
			sync_prev_q <= 1'b0;
			deb_cnt_q <= '0;
		end else begin
			sync_prev_q <= sync_stable_q;
			if (sample_tick) begin
				deb_cnt_q <= (deb_diff && !deb_done) ? deb_cnt_q + 5'h01 : '0;
				if (deb_done) begin
					sync_stable_q <= sync_raw;
				end
			end
		end
	end

	// ---------------- threshold crossings and fault records ----------------
	function automatic logic [2:0] first_stage(logic [`N_STAGES-1:0] v);
		logic [2:0] s;
		s = '0;
		for (int i = `N_STAGES - 1; i >= 0; i--) begin
			if (v[i]) begin
				s = 3'(i);
			end
		end
		return s;
	endfunction

	logic [`N_STAGES-1:0] cross_q;
	wire  [`N_STAGES-1:0] cross_on = thresh_cross & thresh_en;
	wire  [`N_STAGES-1:0] new_cross = cross_on & ~cross_q;
	wire                  fault_new = |new_cross;
	fault_t               flt_mem [`FLT_DEPTH];
	logic [4:0]           flt_ptr_q;
	logic [15:0]          fault_cnt_q;
	logic                 flt_evt_pend_q;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			cross_q <= '0;
			flt_ptr_q <= '0;
			fault_cnt_q <= '0;
			flt_evt_pend_q <= 1'b0;
		end else begin
			cross_q <= cross_on;
			if (fault_new) begin
				flt_ptr_q <= (flt_ptr_q == 5'(`FLT_DEPTH - 1)) ? '0 : flt_ptr_q + 5'h01;
				fault_cnt_q <= fault_cnt_q + 16'h0001;
			end
			// event goes in at the next millisecond tick; its stamp lags by one ms only if the fault fell on a tick cycle
			if (fault_new) begin
				flt_evt_pend_q <= 1'b1;
			end else if (ms_tick) begin
				flt_evt_pend_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (fault_new) begin
			flt_mem[flt_ptr_q] <= '{stamp: rtc_q, stages: new_cross};
		end
	end

	// ---------------- event log ----------------
	event_t     evt_mem [`EVT_DEPTH];
	logic [7:0] evt_ptr_q;
	wire        flt_evt_we = flt_evt_pend_q & ms_tick & ~fault_new;
	assign event_ready = ~flt_evt_we;
	wire        evt_we = flt_evt_we | (event_valid & event_ready);
	wire  [7:0] evt_code_w = flt_evt_we ? `FAULT_EVT_CODE : event_code;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			evt_ptr_q <= '0;
		end else if (evt_we) begin
			// oldest entry is overwritten once the ring is full
			evt_ptr_q <= (evt_ptr_q == 8'(`EVT_DEPTH - 1)) ? '0 : evt_ptr_q + 8'h01;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (evt_we) begin
			evt_mem[evt_ptr_q] <= '{stamp: rtc_q, code: evt_code_w};
		end
	end

	// ---------------- starting records ----------------
	start_rec_t st_mem [`START_DEPTH];
	start_rec_t st_cur_q;
	logic       st_active_q;
	logic [2:0] st_ptr_q;
	wire        st_open = fault_new & ~st_active_q;
	wire        st_close = st_active_q & ~cross_on[st_cur_q.stage];

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			st_cur_q <= '0;
			st_active_q <= 1'b0;
			st_ptr_q <= '0;
		end else if (st_open) begin
			st_active_q <= 1'b1;
			st_cur_q <= '{fault_count: fault_cnt_q + 16'h0001, stamp: rtc_q,
			              stage: first_stage(new_cross), dur_ms: '0, tripped: trip};
		end else if (st_close) begin
			st_active_q <= 1'b0;
			st_ptr_q <= (st_ptr_q == 3'(`START_DEPTH - 1)) ? '0 : st_ptr_q + 3'h1;
		end else if (st_active_q) begin
			if (ms_tick) begin
				st_cur_q.dur_ms <= st_cur_q.dur_ms + 16'h0001;
			end
			if (trip) begin
				st_cur_q.tripped <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (st_close) begin
			st_mem[st_ptr_q] <= st_cur_q;
		end
	end

	// ---------------- disturbance recorder ----------------
	sample_t     dist_mem [DIST_DEPTH];
	dmeta_t      dmeta_mem [`SLOTS_A];
	logic [15:0] slot_len;
	logic [2:0]  n_slots;
	always_comb begin
		unique case (rec_len)
			LEN_3S: begin
				slot_len = 16'(`LEN_A_S * SPS);
				n_slots = 3'(`SLOTS_A);
			end
			LEN_5S: begin
				slot_len = 16'(`LEN_B_S * SPS);
				n_slots = 3'(`SLOTS_B);
			end
			LEN_7S: begin
				slot_len = 16'(`LEN_C_S * SPS);
				n_slots = 3'(`SLOTS_C);
			end
			default: begin
				slot_len = 16'(`LEN_D_S * SPS);
				n_slots = 3'(`SLOTS_D);
			end
		endcase
	end

	dr_state_t   dr_q;
	rec_len_t    len_q;
	logic [2:0]  slot_q;
	logic [15:0] wr_off_q;
	logic [15:0] post_left_q;
	dmeta_t      meta_q;
	// pre-trigger is limited to one slot minus one sample
	wire  [15:0] pre_w = (pretrig_samples >= slot_len) ? slot_len - 16'h0001 : pretrig_samples;
	wire  [15:0] start_w = (wr_off_q >= pre_w) ? wr_off_q - pre_w : wr_off_q + slot_len - pre_w;
	wire  [DAW-1:0] dist_addr = DAW'(32'(slot_q) * 32'(slot_len) + 32'(wr_off_q));
	wire         len_chg = rec_len != len_q;
	wire         dr_done = (dr_q == DR_POST) && sample_tick && (post_left_q == 16'h0001);
	assign dist_busy = (dr_q == DR_POST);

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			dr_q <= DR_ARM;
			len_q <= LEN_3S;
			slot_q <= '0;
			wr_off_q <= '0;
			post_left_q <= '0;
			meta_q <= '0;
		end else if (len_chg) begin
			// new geometry: start the store afresh
			len_q <= rec_len;
			dr_q <= DR_ARM;
			slot_q <= '0;
			wr_off_q <= '0;
		end else begin
			if (sample_tick) begin
				wr_off_q <= (wr_off_q == slot_len - 16'h0001) ? '0 : wr_off_q + 16'h0001;
			end
			unique case (dr_q)
				DR_ARM: begin
					if (fault_new) begin
						dr_q <= DR_POST;
						post_left_q <= slot_len - pre_w;
						meta_q <= '{stamp: rtc_q, start_off: start_w, ct_ratio: ct_ratio,
						            len_samples: slot_len};
					end
				end
				DR_POST: begin
					if (dr_done) begin
						dr_q <= DR_ARM;
						wr_off_q <= '0;
						slot_q <= (slot_q == n_slots - 3'h1) ? '0 : slot_q + 3'h1;
					end else if (sample_tick) begin
						post_left_q <= post_left_q - 16'h0001;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sample_tick && !len_chg) begin
			dist_mem[dist_addr] <= sample_in;
		end
		if (dr_done && !len_chg) begin
			dmeta_mem[slot_q] <= meta_q;
		end
	end

	// ---------------- readout with two-entry buffer ----------------
	rd_rsp_t     buf_q [2];
	logic        bwp_q;
	logic        brp_q;
	logic [1:0]  bcnt_q;
	logic [95:0] rd_data;
	wire  [15:0] ix = rd_req.index;
	assign rd_req_ready = (bcnt_q != 2'h2);
	assign rd_rsp_valid = (bcnt_q != 2'h0);
	assign rd_rsp = buf_q[brp_q];
	wire push = rd_req_valid & rd_req_ready;
	wire pop = rd_rsp_valid & rd_rsp_ready;

	// out of range index answers zero; any port reads any store
	always_comb begin
		rd_data = '0;
		unique case (rd_req.store)
			ST_EVENT: if (ix < 16'(`EVT_DEPTH)) rd_data = 96'(evt_mem[ix[7:0]]);
			ST_FAULT: if (ix < 16'(`FLT_DEPTH)) rd_data = 96'(flt_mem[ix[4:0]]);
			ST_START: if (ix < 16'(`START_DEPTH)) rd_data = 96'(st_mem[ix[2:0]]);
			ST_DIST:  if (32'(ix) < DIST_DEPTH) rd_data = 96'(dist_mem[ix[DAW-1:0]]);
			ST_DMETA: if (ix < 16'(`SLOTS_A)) rd_data = 96'(dmeta_mem[ix[2:0]]);
			default:  rd_data = '0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			bwp_q <= 1'b0;
			brp_q <= 1'b0;
			bcnt_q <= '0;
			buf_q[0] <= '0;
			buf_q[1] <= '0;
		end else begin
			if (push) begin
				buf_q[bwp_q] <= '{port: rd_req.port, data: rd_data};
				bwp_q <= ~bwp_q;
			end
			if (pop) begin
				brp_q <= ~brp_q;
			end
			bcnt_q <= bcnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule

// ### dv/relay_rec_props.sv
// assertion checker for the record keeping and time sync block
`timescale 1ns/1ps
`include "relay_rec_consts.svh"
module relay_rec_props
	import relay_rec_pkg::*;
(
	input wire logic                 ref_clk,
	input wire logic                 nrst,
	input wire logic [`N_STAGES-1:0] thresh_cross,
	input wire logic [`N_STAGES-1:0] thresh_en,
	input wire logic                 event_ready,
	input wire logic                 rd_req_valid,
	input wire logic                 rd_req_ready,
	input wire logic                 rd_rsp_valid,
	input wire rd_rsp_t              rd_rsp,
	input wire logic                 rd_rsp_ready,
	input wire rtc_t                 rtc_now,
	input wire logic                 dist_busy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	rtc_range_a: assert property (
		rtc_now.second < 6'(`SEC_PER_MIN) && rtc_now.minute < 6'(`MIN_PER_HR))
		else $error("rtc out of range");
	sec_step_a: assert property ($changed(rtc_now.second) |->
		rtc_now.second == $past(rtc_now.second) + 6'h01 || rtc_now.second == 6'h00)
		else $error("second skipped");
	ms_step_a: assert property ($changed(rtc_now.msec) |->
		rtc_now.msec == $past(rtc_now.msec) + 10'h001 || rtc_now.msec == 10'h000)
		else $error("msec skipped");
	ev_refuse_a: assert property (!event_ready |=> event_ready)
		else $error("event port refused twice");
	rsp_hold_a: assert property (
		rd_rsp_valid && !rd_rsp_ready |=> rd_rsp_valid && $stable(rd_rsp))
		else $error("response dropped");
	req_answer_a: assert property (rd_req_valid && rd_req_ready |=> rd_rsp_valid)
		else $error("no response");
	full_only_a: assert property (!rd_req_ready |-> rd_rsp_valid)
		else $error("refused while empty");
	port_tag_a: assert property (rd_rsp_valid |-> $onehot(rd_rsp.port))
		else $error("bad port code");
	busy_cause_a: assert property (
		$rose(dist_busy) |-> $past(|(thresh_cross & thresh_en)))
		else $error("capture without trigger");
endmodule
bind relay_record_and_time_sync relay_rec_props i_relay_rec_props (.ref_clk(ref_clk), .nrst(nrst),
	.thresh_cross(thresh_cross), .thresh_en(thresh_en), .event_ready(event_ready),
	.rd_req_valid(rd_req_valid), .rd_req_ready(rd_req_ready), .rd_rsp_valid(rd_rsp_valid),
	.rd_rsp(rd_rsp), .rd_rsp_ready(rd_rsp_ready), .rtc_now(rtc_now), .dist_busy(dist_busy));

// ### dv/rec_reader.sv
// panel or serial port model that pops record words
`timescale 1ns/1ps
module rec_reader
	import relay_rec_pkg::*;
(
	input  wire logic   ref_clk,
	input  wire logic   stall,
	input  wire logic   rd_rsp_valid,
	input  wire rd_rsp_t rd_rsp,
	output logic        rd_rsp_ready,
	output logic [95:0] got,
	output port_t       got_port,
	output int          pops
);
	initial pops = 0;
	// a slow reader simply withholds ready
	assign rd_rsp_ready = !stall;
	always @(posedge ref_clk) begin
		if (rd_rsp_valid && rd_rsp_ready) begin
			got <= rd_rsp.data;
			got_port <= rd_rsp.port;
			pops <= pops + 1;
		end
	end
endmodule

// ### dv/relay_record_and_time_sync_tb.sv
// testbench for the record keeping and time sync block
`timescale 1ns/1ps
module relay_record_and_time_sync_tb;
	import relay_rec_pkg::*;
	logic        ref_clk = 0, nrst = 0, sample_tick = 0, ea_filter_en = 1, trip = 0;
	logic        event_valid = 0, rd_req_valid = 0, stall = 0;
	logic [7:0]  logic_in = '0, event_code = '0;
	logic [2:0]  sync_sel = 3'h3;
	logic [5:0]  thresh_cross = '0;
	sample_t     sample_in = '0;
	rd_req_t     rd_req = '0;
	logic        event_ready, rd_req_ready, rd_rsp_valid, rd_rsp_ready, dist_busy;
	rd_rsp_t     rd_rsp;
	port_t       got_port;
	rec_len_t    rec_len = LEN_3S;
	rtc_t        rtc_now;
	logic [95:0] got;
	int          pops, bad_count = 0, total_checks = 0;
	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) sample_tick <= ~sample_tick;
	always @(posedge ref_clk) sample_in <= sample_in + 1;
	// one ms per clock keeps the round-up case inside the run
	relay_record_and_time_sync #(.MS_CYCLES(1), .SPS(20)) i_relay_record_and_time_sync (
		.ref_clk(ref_clk), .nrst(nrst), .sample_tick(sample_tick), .logic_in(logic_in),
		.sync_sel(sync_sel), .ea_filter_en(ea_filter_en), .thresh_cross(thresh_cross),
		.thresh_en(6'h3f), .trip(trip), .event_valid(event_valid), .event_code(event_code),
		.event_ready(event_ready), .sample_in(sample_in), .ct_ratio(16'h1234),
		.rec_len(rec_len), .pretrig_samples(16'h000a), .rd_req_valid(rd_req_valid),
		.rd_req(rd_req), .rd_req_ready(rd_req_ready), .rd_rsp_valid(rd_rsp_valid),
		.rd_rsp(rd_rsp), .rd_rsp_ready(rd_rsp_ready), .rtc_now(rtc_now), .dist_busy(dist_busy));
	rec_reader i_rec_reader (.ref_clk(ref_clk), .stall(stall), .rd_rsp_valid(rd_rsp_valid),
		.rd_rsp(rd_rsp), .rd_rsp_ready(rd_rsp_ready), .got(got), .got_port(got_port),
		.pops(pops));
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [95:0] g, input logic [95:0] e);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic guard(input int i, input int lim);
		if (i >= lim) begin
			bad_count++;
			$display("unexpected hang at %0t: %h of %h", $time, i, lim);
			wrap_up();
		end
	endtask
	task automatic rd(input port_t p, input store_t s, input logic [15:0] idx,
		output logic [95:0] d);
		int i, n;
		n = pops;
		rd_req <= '{p, s, idx};
		rd_req_valid <= 1;
		for (i = 0; i < 20; i++) begin
			@(negedge ref_clk);
			if (rd_req_ready) break;
			@(posedge ref_clk);
		end
		guard(i, 20);
		@(posedge ref_clk);
		rd_req_valid <= 0;
		for (i = 0; i < 20 && pops == n; i++) @(negedge ref_clk);
		guard(i, 20);
		d = got;
		@(posedge ref_clk);
	endtask
	task automatic t_events;
		logic [95:0] d;
		for (int k = 0; k < 251; k++) begin
			event_valid <= 1;
			event_code <= k[7:0];
			@(posedge ref_clk);
		end
		event_valid <= 0;
		rd(PORT_FRONT, ST_EVENT, 16'h0000, d);
		chk(d[7:0], 8'hfa);
		rd(PORT_LOCAL, ST_EVENT, 16'h0001, d);
		chk(d[7:0], 8'h01);
		rd(PORT_REMOTE, ST_EVENT, 16'h00f9, d);
		chk(d[7:0], 8'hf9);
		chk(d[17:8] < 10'd1000, 1);
		rd(PORT_FRONT, ST_EVENT, 16'h00fa, d);
		chk(d, 0);
		$display("test events done");
	endtask
	task automatic pulse(input logic [5:0] st, input int len);
		int i;
		thresh_cross <= st;
		trip <= 1;
		repeat (len) @(posedge ref_clk);
		thresh_cross <= '0;
		trip <= 0;
		for (i = 0; i < 400 && dist_busy; i++) @(negedge ref_clk);
		guard(i, 400);
		@(posedge ref_clk);
	endtask
	task automatic t_fault;
		logic [95:0] d;
		pulse(6'h08, 5);
		rd(PORT_FRONT, ST_FAULT, 16'h0000, d);
		chk(d[5:0], 6'h08);
		rd(PORT_FRONT, ST_START, 16'h0000, d);
		chk({d[19:17], d[0]}, 4'h7);
		chk(d[16:1] != 0, 1);
		rd(PORT_FRONT, ST_EVENT, 16'h0001, d);
		chk(d[7:0], 8'hf0);
		rd(PORT_FRONT, ST_DMETA, 16'h0000, d);
		chk(d[31:0], 32'h1234_003c);
		for (int k = 1; k < 26; k++) pulse(6'h01 << (k % 5), 3);
		rd(PORT_LOCAL, ST_FAULT, 16'h0000, d);
		chk(d[5:0], 6'h01);
		rd(PORT_LOCAL, ST_FAULT, 16'h0001, d);
		chk(d[5:0], 6'h02);
		rd(PORT_LOCAL, ST_START, 16'h0000, d);
		chk(d[19:17], 3'h0);
		$display("test faults done");
	endtask
	task automatic t_sync;
		int i;
		logic [5:0] m;
		for (i = 0; i < 3000 && rtc_now.second < 2; i++) @(posedge ref_clk);
		guard(i, 3000);
		logic_in[3] <= 1;
		repeat (20) @(posedge ref_clk);
		logic_in[3] <= 0;
		repeat (60) @(posedge ref_clk);
		chk(rtc_now.second == 0, 0);
		m = rtc_now.minute;
		logic_in[3] <= 1;
		for (i = 0; i < 100 && rtc_now.second != 0; i++) @(negedge ref_clk);
		guard(i, 100);
		chk({rtc_now.minute, rtc_now.msec < 10'd4}, {m, 1'b1});
		repeat (100) @(posedge ref_clk);
		chk(rtc_now.msec > 10'd50, 1);
		for (i = 0; i < 40000 && rtc_now.second < 31; i++) @(posedge ref_clk);
		guard(i, 40000);
		ea_filter_en <= 0;
		sync_sel <= 3'h5;
		repeat (4) @(posedge ref_clk);
		logic_in[5] <= 1;
		for (i = 0; i < 100 && rtc_now.second != 0; i++) @(negedge ref_clk);
		guard(i, 100);
		chk(rtc_now.minute, m + 6'h01);
		@(posedge ref_clk);
		repeat (19) @(posedge ref_clk);
		logic_in[5] <= 0;
		$display("test sync done");
	endtask
	task automatic t_stall;
		int i, n, acc;
		n = pops;
		acc = 0;
		stall <= 1;
		rd_req <= '{PORT_REMOTE, ST_EVENT, 16'h0030};
		rd_req_valid <= 1;
		for (i = 0; i < 10; i++) begin
			@(negedge ref_clk);
			if (!rd_req_ready) break;
			@(posedge ref_clk);
			acc++;
		end
		@(posedge ref_clk);
		rd_req_valid <= 0;
		chk(acc, 2);
		chk(pops, n);
		stall <= 0;
		for (i = 0; i < 20 && pops != n + 2; i++) @(negedge ref_clk);
		guard(i, 20);
		chk(got[7:0], 8'h30);
		chk(got_port, PORT_REMOTE);
		$display("test stall done");
	endtask
	task automatic t_dist;
		logic [95:0] d;
		logic [42:0] s1;
		@(posedge ref_clk);
		rec_len <= LEN_7S;
		@(posedge ref_clk);
		// two 7 s slots: the third capture must land on slot 0 again
		repeat (3) pulse(6'h02, 3);
		rd(PORT_REMOTE, ST_DMETA, 16'h0001, d);
		chk(d[31:0], 32'h1234_008c);
		s1 = d[90:48];
		rd(PORT_REMOTE, ST_DMETA, 16'h0000, d);
		chk(d[31:0], 32'h1234_008c);
		chk(d[90:48] > s1, 1);
		$display("test disturbance done");
	endtask
	initial begin
		repeat (8) @(posedge ref_clk);
		nrst <= 1;
		@(posedge ref_clk);
		t_events();
		t_fault();
		t_sync();
		t_stall();
		t_dist();
		wrap_up();
	end
endmodule
